// ---- rtl/dac_pkg.sv ----
package dac_pkg;
   // ==================================================================
   // Sizes and timing
   // ==================================================================
   localparam int DAC_SAMPLE_W     = 8;
   localparam int DAC_CAL_PHASE    = 80;     // Sample clocks per phase
   localparam int DAC_SHORT_EXP    = 25;     // Delay 2**25 with select low
   localparam int DAC_LONG_EXP     = 31;     // Delay 2**31 with select high
   localparam int DAC_PRIMARY_LAT  = 13;     // Falling edges to primary bus
   localparam int DAC_DELAYED_LAT  = 14;     // Falling edges to delayed bus
   localparam int DAC_CAL_CYCLES   = 1024;   // Calibration run length
   localparam int DAC_DLY_W        = 32;

   // ==================================================================
   // Register map (Wishbone, byte addresses)
   // ==================================================================
   localparam logic [7:0] DAC_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] DAC_STATUS_ADDR = 8'h04;
   localparam logic [7:0] DAC_EXT_ADDR    = 8'h08;
   localparam logic [7:0] DAC_ID_ADDR     = 8'h0C;
   localparam logic [31:0] DAC_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] DAC_EXT_RST    = 32'h0000_0000;
   localparam logic [31:0] DAC_UNMAPPED   = 32'h0000_0000;
   // CTRL bit positions
   localparam int DAC_CTRL_EXT_BIT  = 0;
   // EXT register field positions
   localparam int DAC_EXT_DRIVE_BIT = 0;
   localparam int DAC_EXT_EDGE_BIT  = 1;
   localparam int DAC_EXT_RANGE_BIT = 2;
   localparam int DAC_EXT_DLY_BIT   = 3;
   // STATUS bit positions
   localparam int DAC_ST_TRIM_BIT   = 0;
   localparam int DAC_ST_RANGE_BIT  = 1;
   localparam int DAC_ST_DONE_BIT   = 2;

   // Effective control settings after pin/register selection
   typedef struct packed {
      logic drive_strength_select;
      logic launch_edge_select;
      logic input_range_select;
      logic trim_delay_select;
   } dac_cfg_s;

   // One converted sample pair with a combined over-range flag
   typedef struct packed {
      logic [DAC_SAMPLE_W-1:0] i_code;
      logic [DAC_SAMPLE_W-1:0] q_code;
      logic                    over_range;
   } dac_sample_s;
endpackage : dac_pkg

// ---- rtl/dac_cal_cmd.sv ----
`timescale 1ns/1ns
// Detects a valid calibration command: low 80 then high 80 sample clocks
module dac_cal_cmd
   import dac_pkg::*;
#(
   parameter int PHASE = DAC_CAL_PHASE
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // Sample clock tick and synchronised pin
   input  wire logic tick,
   input  wire logic cal_level,
   // Result
   output logic      cmd_pulse,
   output logic      armed_low
);
   localparam int CW = $clog2(PHASE + 1);
   logic [CW-1:0] count;
   logic          seen_low;

   // Phase counter in sample clocks; short phases are discarded
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count     <= '0;
         seen_low  <= 1'b0;
         cmd_pulse <= 1'b0;
         armed_low <= 1'b0;
      end else begin
         cmd_pulse <= 1'b0;
         if (tick) begin
            if (!cal_level) begin
               // Low phase: count up to the required length, saturating
               armed_low <= 1'b0;
               if (!seen_low) begin
                  count    <= CW'(1);
                  seen_low <= 1'b1;
               end else if (count != CW'(PHASE)) begin
                  count <= count + CW'(1);
               end
            end else begin
               seen_low <= 1'b0;
               if (seen_low) begin
                  if (count == CW'(PHASE)) begin
                     armed_low <= 1'b1;
                     count     <= CW'(1);
                  end else begin
                     count <= '0;
                  end
               end else if (armed_low) begin
                  if (count == CW'(PHASE - 1)) begin
                     cmd_pulse <= 1'b1;
                     armed_low <= 1'b0;
                     count     <= '0;
                  end else begin
                     count <= count + CW'(1);
                  end
               end
            end
         end
      end
   end
endmodule : dac_cal_cmd

// ---- rtl/dac_latency.sv ----
`timescale 1ns/1ns
// Shift line of sample pairs advanced on each sample clock tick
module dac_latency
   import dac_pkg::*;
#(
   parameter int DEPTH = DAC_DELAYED_LAT
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Stream
   input  wire logic        tick,
   input  wire dac_sample_s din,
   output dac_sample_s      tap_primary,
   output dac_sample_s      tap_delayed
);
   dac_sample_s stage [DEPTH];

   // Storage advances one position per falling sample clock edge
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               stage[g] <= '0;
            end else if (tick) begin
               stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   // Taps at the two documented latencies
   assign tap_primary = stage[DAC_PRIMARY_LAT-1];
   assign tap_delayed = stage[DEPTH-1];
endmodule : dac_latency

// ---- rtl/dac_ctrl.sv ----
`timescale 1ns/1ns
module dac_ctrl
   import dac_pkg::*;
#(
   parameter int SHORT_DELAY = 2**DAC_SHORT_EXP,
   parameter longint LONG_DELAY = 64'h0000_0000_0000_0001 << DAC_LONG_EXP,
   parameter int CAL_CYCLES  = DAC_CAL_CYCLES
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   // Wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // Sample clock and converted codes
   input  wire logic                    sample_clk,
   input  wire logic [DAC_SAMPLE_W-1:0] i_raw,
   input  wire logic [DAC_SAMPLE_W-1:0] q_raw,
   input  wire logic                    i_under,
   input  wire logic                    i_over,
   input  wire logic                    q_under,
   input  wire logic                    q_over,
   // Control pins
   input  wire logic                    cal_request,
   input  wire logic                    sleep_request,
   input  wire logic                    trim_delay_select,
   input  wire logic                    input_range_select,
   input  wire logic                    drive_strength_select,
   input  wire logic                    launch_edge_select,
   // Outputs
   output logic      [DAC_SAMPLE_W-1:0] i_primary_bus,
   output logic      [DAC_SAMPLE_W-1:0] i_delayed_bus,
   output logic      [DAC_SAMPLE_W-1:0] q_primary_bus,
   output logic      [DAC_SAMPLE_W-1:0] q_delayed_bus,
   output logic                         out_of_range,
   output logic                         trim_in_progress,
   output dac_cfg_s                     cfg_out
);
   // ==================================================================
   // Synchronisers
   // ==================================================================
   localparam int NSYNC = 8;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic [NSYNC-1:0] pins_in;
   logic             clk_q;
   logic             tick;

   assign pins_in = {sample_clk, cal_request, sleep_request,
                     trim_delay_select, input_range_select,
                     drive_strength_select, launch_edge_select, 1'b0};

   // Two flip-flops on the sample clock and every control pin from outside the clock domain
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= pins_in;
         sync_b <= sync_a;
      end
   end

   wire clk_s   = sync_b[7];
   wire cal_s   = sync_b[6];
   wire sleep_s = sync_b[5];

   // Falling edge of the sample clock marks a sample
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_q <= 1'b0;
      end else begin
         clk_q <= clk_s;
      end
   end
   assign tick = clk_q && !clk_s;

   // ==================================================================
   // Registers
   // ==================================================================
   logic [31:0] ctrl_reg;
   logic [31:0] ext_reg;
   logic        cal_done;
   wire         wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire         ext_mode = ctrl_reg[DAC_CTRL_EXT_BIT];

   // Byte-lane write
   function automatic logic [31:0] lane_write(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_write

   // Register writes, ack one cycle after the request
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= DAC_CTRL_RST;
         ext_reg  <= DAC_EXT_RST;
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && wb_we_i) begin
            if (wb_adr_i == DAC_CTRL_ADDR) begin
               ctrl_reg <= lane_write(ctrl_reg, wb_dat_i, wb_sel_i)
                           & 32'h0000_0001;
            end
            if (wb_adr_i == DAC_EXT_ADDR) begin
               ext_reg <= lane_write(ext_reg, wb_dat_i, wb_sel_i)
                          & 32'h0000_000F;
            end
         end
      end
   end

   // Read data
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= DAC_UNMAPPED;
      end else if (wb_req && !wb_we_i) begin
         case (wb_adr_i)
            DAC_CTRL_ADDR:   wb_dat_o <= ctrl_reg;
            DAC_EXT_ADDR:    wb_dat_o <= ext_reg;
            DAC_STATUS_ADDR: wb_dat_o <= {29'd0, cal_done, out_of_range,
                                          trim_in_progress};
            default:         wb_dat_o <= DAC_UNMAPPED;
         endcase
      end
   end

   // ==================================================================
   // Pin or register control selection
   // ==================================================================
   dac_cfg_s cfg;
   always_comb begin
      if (ext_mode) begin
         cfg.drive_strength_select = ext_reg[DAC_EXT_DRIVE_BIT];
         cfg.launch_edge_select    = ext_reg[DAC_EXT_EDGE_BIT];
         cfg.input_range_select    = ext_reg[DAC_EXT_RANGE_BIT];
         cfg.trim_delay_select     = ext_reg[DAC_EXT_DLY_BIT];
      end else begin
         cfg.drive_strength_select = sync_b[2];
         cfg.launch_edge_select    = sync_b[1];
         cfg.input_range_select    = sync_b[3];
         cfg.trim_delay_select     = sync_b[4];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_out <= '0;
      end else begin
         cfg_out <= cfg;
      end
   end

   // ==================================================================
   // Calibration sequencer
   // ==================================================================
   typedef enum logic [1:0] {ST_WAIT, ST_IDLE, ST_RUN} dac_cal_e;
   dac_cal_e        state;
   logic [DAC_DLY_W-1:0] dly_cnt;
   logic [DAC_DLY_W-1:0] run_cnt;
   logic            first_tick;
   logic            suppressed;
   logic            cmd_pulse;

   dac_cal_cmd #(.PHASE(DAC_CAL_PHASE)) u_cmd (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .tick      (tick),
      .cal_level (cal_s),
      .cmd_pulse (cmd_pulse),
      .armed_low ()
   );

   wire [DAC_DLY_W-1:0] dly_target = cfg.trim_delay_select ?
        DAC_DLY_W'(LONG_DELAY) : DAC_DLY_W'(SHORT_DELAY);

   // Power-up delay, command start, run and sleep interlock
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= ST_WAIT;
         dly_cnt    <= '0;
         run_cnt    <= '0;
         first_tick <= 1'b1;
         suppressed <= 1'b0;
         cal_done   <= 1'b0;
      end else begin
         if (tick) begin
            first_tick <= 1'b0;
            if (first_tick && cal_s) begin
               suppressed <= 1'b1;
            end
         end
         case (state)
            ST_WAIT: begin
               if (cmd_pulse && !sleep_s) begin
                  state   <= ST_RUN;
                  run_cnt <= '0;
               end else if (tick && !sleep_s && !suppressed &&
                            !(first_tick && cal_s)) begin
                  if (dly_cnt >= dly_target - DAC_DLY_W'(1)) begin
                     state   <= ST_RUN;
                     run_cnt <= '0;
                  end else begin
                     dly_cnt <= dly_cnt + DAC_DLY_W'(1);
                  end
               end
            end
            ST_IDLE: begin
               if (cmd_pulse && !sleep_s) begin
                  state   <= ST_RUN;
                  run_cnt <= '0;
               end
            end
            ST_RUN: begin
               // Commands here are ignored until completion or sleep
               if (sleep_s) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  if (run_cnt == DAC_DLY_W'(CAL_CYCLES - 1)) begin
                     state    <= ST_IDLE;
                     cal_done <= 1'b1;
                  end else begin
                     run_cnt <= run_cnt + DAC_DLY_W'(1);
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Busy output tracks the running state
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         trim_in_progress <= 1'b0;
      end else begin
         trim_in_progress <= (state == ST_RUN) && !sleep_s;
      end
   end

   // ==================================================================
   // Data path
   // ==================================================================
   function automatic logic [DAC_SAMPLE_W-1:0] clamp(
         input logic [DAC_SAMPLE_W-1:0] code,
         input logic under, input logic over);
      if (under) begin
         return '0;
      end else if (over) begin
         return '1;
      end
      return code;
   endfunction : clamp

   dac_sample_s din;
   dac_sample_s tap_p;
   dac_sample_s tap_d;
   logic        phase;

   assign din.i_code     = clamp(i_raw, i_under, i_over);
   assign din.q_code     = clamp(q_raw, q_under, q_over);
   assign din.over_range = i_under | i_over | q_under | q_over;

   dac_latency #(.DEPTH(DAC_DELAYED_LAT)) u_lat (
      .sys_clk     (sys_clk),
      .reset_n     (reset_n),
      .tick        (tick),
      .din         (din),
      .tap_primary (tap_p),
      .tap_delayed (tap_d)
   );

   // Demux: buses update on every second sample, hold during sleep
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase         <= 1'b0;
         i_primary_bus <= '0;
         i_delayed_bus <= '0;
         q_primary_bus <= '0;
         q_delayed_bus <= '0;
         out_of_range  <= 1'b0;
      end else if (tick && !sleep_s) begin
         phase <= !phase;
         if (phase) begin
            i_primary_bus <= tap_p.i_code;
            i_delayed_bus <= tap_d.i_code;
            q_primary_bus <= tap_p.q_code;
            q_delayed_bus <= tap_d.q_code;
            out_of_range  <= tap_p.over_range | tap_d.over_range;
         end
      end
   end
endmodule : dac_ctrl

// ---- tb/dac_ctrl_checker.sv ----
`timescale 1ns/1ns
// ============
// Port checker
module dac_ctrl_checker
   import dac_pkg::*;
#(
   parameter int SHORT_DELAY = 20,
   parameter int CAL_CYCLES  = 16
) (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    reset_n,
   // Register bus
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_we_i,
   input wire logic [7:0]              wb_adr_i,
   input wire logic [31:0]             wb_dat_o,
   input wire logic                    wb_ack_o,
   // Pins
   input wire logic                    sleep_request,
   input wire logic [DAC_SAMPLE_W-1:0] i_primary_bus,
   input wire logic [DAC_SAMPLE_W-1:0] q_delayed_bus,
   input wire logic                    trim_in_progress
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] since_rst;
   logic [15:0] run_cnt;
   // Cycles since reset release, saturating
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) since_rst <= 16'h0000;
      else if (since_rst != 16'hffff) since_rst <= since_rst + 16'h0001;
   end
   // Length of the current calibration run
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) run_cnt <= 16'h0000;
      else if (trim_in_progress) run_cnt <= run_cnt + 16'h0001;
      else run_cnt <= 16'h0000;
   end
   // ==========
   // Assertions
   a_ack_one_cycle:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_follows_req:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_unmapped_zero:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c
                       |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   a_sleep_stops_trim:
      assert property (sleep_request && $past(sleep_request, 8) &&
                       $past(sleep_request, 16) |-> !trim_in_progress)
      else $error("calibration running during sleep");
   a_trim_after_delay:
      assert property (trim_in_progress |-> since_rst >= SHORT_DELAY*8-16)
      else $error("calibration began before the power-up delay");
   a_trim_min_run:
      assert property ($rose(trim_in_progress) && !sleep_request
                       |=> trim_in_progress[*8])
      else $error("calibration flag dropped too early");
   a_trim_max_run:
      assert property (run_cnt <= CAL_CYCLES*8+8)
      else $error("calibration flag held too long");
   a_i_demux_hold:
      assert property ($changed(i_primary_bus)
                       |=> $stable(i_primary_bus)[*8])
      else $error("primary bus changed faster than half rate");
   a_q_demux_hold:
      assert property ($changed(q_delayed_bus)
                       |=> $stable(q_delayed_bus)[*8])
      else $error("delayed bus changed faster than half rate");
endmodule : dac_ctrl_checker

bind dac_ctrl dac_ctrl_checker #(.SHORT_DELAY(SHORT_DELAY),
   .CAL_CYCLES(CAL_CYCLES)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sleep_request(sleep_request), .i_primary_bus(i_primary_bus),
   .q_delayed_bus(q_delayed_bus), .trim_in_progress(trim_in_progress));

// ---- tb/dac_far_end.sv ----
`timescale 1ns/1ns
// ==============
// Capture model
module dac_far_end
   import dac_pkg::*;
(
   // Sample clock
   output logic                         sample_clk,
   // Half-rate buses from the converter
   input  wire logic [DAC_SAMPLE_W-1:0] i_primary_bus,
   input  wire logic [DAC_SAMPLE_W-1:0] i_delayed_bus,
   // Rebuilt full-rate pair, older sample first
   output logic      [DAC_SAMPLE_W-1:0] i_early,
   output logic      [DAC_SAMPLE_W-1:0] i_late
);
   // Free running 32 ns clock, offset from the system clock
   initial begin
      sample_clk = 1'b1;
      #1;
      forever #16 sample_clk = ~sample_clk;
   end
   // Latch mid-period and re-interleave the two buses
   always @(posedge sample_clk) begin
      i_early <= i_delayed_bus;
      i_late  <= i_primary_bus;
   end
endmodule : dac_far_end

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
// =========
// Testbench
module testbench
   import dac_pkg::*;
;
   localparam int SHORT = 20;
   localparam int LONG  = 40;
   localparam int CAL   = 16;
   logic        sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic        sample_clk, out_of_range, trim_in_progress;
   logic [7:0]  i_raw, q_raw, i_early, i_late;
   logic [7:0]  i_primary_bus, i_delayed_bus, q_primary_bus, q_delayed_bus;
   logic        i_under, i_over, q_under, q_over, cal_request;
   logic        sleep_request, trim_delay_select, input_range_select;
   logic        drive_strength_select, launch_edge_select;
   dac_cfg_s    cfg_out;
   int          error_cnt, checked, rise, len;
   logic [20:0] tab [3];

   dac_ctrl #(.SHORT_DELAY(SHORT), .LONG_DELAY(LONG), .CAL_CYCLES(CAL)) uut (
      .sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_clk, .i_raw,
      .q_raw, .i_under, .i_over, .q_under, .q_over, .cal_request,
      .sleep_request, .trim_delay_select, .input_range_select,
      .drive_strength_select, .launch_edge_select, .i_primary_bus,
      .i_delayed_bus, .q_primary_bus, .q_delayed_bus, .out_of_range,
      .trim_in_progress, .cfg_out);
   dac_far_end far (.sample_clk, .i_primary_bus, .i_delayed_bus, .i_early,
      .i_late);

   // 250 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // =====
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic near(input int v, input int e);
      check(v >= e - 8 && v <= e + 24, 32'h0000_0001);
   endtask : near
   task automatic end_sim;
      $display("Checks %0d, errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n == 50) begin
         error_cnt++;
         end_sim();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic power_up(input logic cal, input logic slp, input logic dly);
      @(posedge sys_clk);
      reset_n           <= 1'b0;
      cal_request       <= cal;
      sleep_request     <= slp;
      trim_delay_select <= dly;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
   endtask : power_up
   task automatic ticks(input int n);
      repeat (n) @(negedge sample_clk);
      @(posedge sys_clk);
   endtask : ticks
   task automatic meas(input int lim);
      rise = 0;
      while (trim_in_progress !== 1'b1 && rise < lim) begin
         @(posedge sys_clk);
         rise++;
      end
   endtask : meas
   task automatic runlen;
      len = 0;
      while (trim_in_progress === 1'b1 && len < 1000) begin
         @(posedge sys_clk);
         len++;
      end
      check(len >= CAL * 8 - 8 && len <= CAL * 8 + 8, 32'h0000_0001);
   endtask : runlen
   task automatic cmd(input int low_ticks);
      @(posedge sys_clk);
      cal_request <= 1'b0;
      ticks(low_ticks);
      cal_request <= 1'b1;
   endtask : cmd
   // Cut a hang short
   initial begin
      repeat (100000) @(posedge sys_clk);
      error_cnt++;
      end_sim();
   end
   // =========
   // Sequence
   initial begin
      {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
      {wb_dat_i, i_under, i_over, q_under, q_over, cal_request} = '0;
      {sleep_request, trim_delay_select, input_range_select} = '0;
      {drive_strength_select, launch_edge_select} = '0;
      i_raw = 8'h55;
      q_raw = 8'h33;
      tab[0] = {4'h9, 8'h00, 8'hff, 1'b1};
      tab[1] = {4'h4, 8'hff, 8'h33, 1'b1};
      tab[2] = {4'h0, 8'h55, 8'h33, 1'b0};
      power_up(1'b0, 1'b0, 1'b0);
      meas(4000);
      near(rise, SHORT * 8);
      runlen();
      $display("Test done: power-up calibration");
      wb(1'b0, DAC_CTRL_ADDR, 32'h0000_0000);
      check(rd, DAC_CTRL_RST);
      wb(1'b0, DAC_EXT_ADDR, 32'h0000_0000);
      check(rd, DAC_EXT_RST);
      wb(1'b1, 8'h10, 32'h0000_00ff);
      wb(1'b0, 8'h10, 32'h0000_0000);
      check(rd, DAC_UNMAPPED);
      {drive_strength_select, launch_edge_select} <= 2'h1;
      {input_range_select, trim_delay_select} <= 2'h1;
      repeat (4) @(posedge sys_clk);
      check(cfg_out, 32'h0000_0005);
      wb(1'b1, DAC_EXT_ADDR, 32'h0000_0005);
      wb(1'b1, DAC_CTRL_ADDR, 32'h0000_0001);
      wb(1'b0, DAC_EXT_ADDR, 32'h0000_0000);
      check(rd, 32'h0000_0005);
      repeat (4) @(posedge sys_clk);
      check(cfg_out, 32'h0000_000a);
      wb(1'b1, DAC_CTRL_ADDR, 32'h0000_0000);
      repeat (4) @(posedge sys_clk);
      check(cfg_out, 32'h0000_0005);
      // Pin control is kept from here to the end of the run
      $display("Test done: control mode");
      foreach (tab[k]) begin
         {i_under, i_over, q_under, q_over} <= tab[k][20:17];
         ticks(20);
         check(i_primary_bus, tab[k][16:9]);
         check(i_delayed_bus, tab[k][16:9]);
         check(q_primary_bus, tab[k][8:1]);
         check(q_delayed_bus, tab[k][8:1]);
         check(out_of_range, tab[k][0]);
      end
      ticks(1);
      i_raw <= 8'haa;
      ticks(12);
      check(i_primary_bus, 8'h55);
      check(i_delayed_bus, 8'h55);
      ticks(4);
      check(i_primary_bus, 8'haa);
      check(i_delayed_bus, 8'haa);
      repeat (30) begin
         ticks(1);
         i_raw <= (i_raw == 8'h11) ? 8'h22 : 8'h11;
      end
      check(i_early ^ i_late, 32'h0000_0033);
      $display("Test done: data path");
      power_up(1'b0, 1'b0, 1'b1);
      meas(4000);
      near(rise, LONG * 8);
      power_up(1'b0, 1'b1, 1'b0);
      meas(600);
      check(rise, 600);
      sleep_request <= 1'b0;
      meas(4000);
      near(rise, SHORT * 8);
      runlen();
      $display("Test done: power-up delays");
      power_up(1'b1, 1'b0, 1'b0);
      meas(600);
      check(rise, 600);
      input_range_select <= 1'b1; // Range change needs a command
      cmd(82); // Command after settling
      meas(4000);
      near(rise, DAC_CAL_PHASE * 8);
      runlen();
      cmd(70);
      meas(1000);
      check(rise, 1000);
      cmd(82);
      meas(4000);
      near(rise, DAC_CAL_PHASE * 8);
      repeat (40) @(posedge sys_clk);
      sleep_request <= 1'b1;
      repeat (40) @(posedge sys_clk);
      check(trim_in_progress, 1'b0);
      sleep_request <= 1'b0;
      meas(600);
      check(rise, 600);
      $display("Test done: commanded calibration");
      end_sim();
   end
endmodule : testbench
